// ---- pkg/ffss_regs.svh ----
// Purpose: Register offsets, fields, reset values and counts of the correction set selector
// Assumes: Avalon-MM byte addresses, one 32-bit word per register
// Notes:   Definitions only
`ifndef FFSS_REGS_SVH
`define FFSS_REGS_SVH

// ----------------------------------------
// Sizes
// ----------------------------------------
`define FFSS_ADDR_W 6
`define FFSS_NUM_SETS 16
`define FFSS_ENTRY_W 8
`define FFSS_SET_W 4

// ----------------------------------------
// Offsets
// ----------------------------------------
`define FFSS_OFS_MODE 6'h00
`define FFSS_OFS_ACQ 6'h04
`define FFSS_OFS_MANUAL 6'h08
`define FFSS_OFS_SET_SEL 6'h0C
`define FFSS_OFS_PAIR 6'h10
`define FFSS_OFS_RECONNECT 6'h14
`define FFSS_OFS_LIST_WR 6'h18
`define FFSS_OFS_STATUS 6'h1C

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define FFSS_LIST_BASE_LSB 8
`define FFSS_LIST_LEN_LSB 16
`define FFSS_STAT_SET_LSB 8
`define FFSS_STAT_PEND_BIT 12
`define FFSS_STAT_POS_LSB 16
`define FFSS_RST_MODE 1'b0
`define FFSS_RST_MANUAL 8'h00

`endif

// ---- pkg/ffss_pkg.sv ----
// Purpose: Types shared by the correction set selector and its list memory
// Assumes: Sizes from ffss_regs.svh
// Notes:   No constants beyond widths
`include "ffss_regs.svh"

package ffss_pkg;
	typedef logic [`FFSS_ENTRY_W-1:0] ffss_entry_t;
	typedef logic [`FFSS_SET_W-1:0] ffss_set_t;
	typedef enum logic {FFSS_MODE_OFF, FFSS_MODE_AUTO} ffss_mode_e;
	// One list: first entry and number of entries
	typedef struct packed {
		ffss_entry_t len;
		ffss_entry_t base;
	} ffss_list_s;
endpackage : ffss_pkg

// ---- pkg/ffss_tbl_if.sv ----
// Purpose: Carrier between the selector and its list memory
// Assumes: Single clock, registered read data
// Notes:   Read data follow the read address by one edge
`timescale 1ns/100ps

interface ffss_tbl_if;
	logic wr_en;
	ffss_pkg::ffss_set_t wr_addr;
	ffss_pkg::ffss_list_s wr_data;
	ffss_pkg::ffss_set_t rd_addr;
	ffss_pkg::ffss_list_s rd_data;
	modport ctrl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
	modport mem (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface : ffss_tbl_if

// ---- verilog/ffss_list_mem.sv ----
// Purpose: Holds one list descriptor per correction set
// Assumes: Synchronous reset clears all lists
// Notes:   Read data come from a register
`timescale 1ns/100ps
`include "ffss_regs.svh"

module ffss_list_mem #(
	parameter int SETS = `FFSS_NUM_SETS
) (
	// Clock and reset
	input wire logic CLK,
	input wire logic SRST,
	// Table access
	ffss_tbl_if.mem tbl
);
	ffss_pkg::ffss_list_s mem [SETS];

	// Storage, cleared so no unknown list is ever applied
	always_ff @(posedge CLK) begin
		if (SRST) begin
			for (int i = 0; i < SETS; i++) begin
				mem[i] <= '0;
			end
		end else if (tbl.wr_en) begin
			mem[tbl.wr_addr] <= tbl.wr_data;
		end
	end

	// Registered read port
	always_ff @(posedge CLK) begin
		if (SRST) begin
			tbl.rd_data <= '0;
		end else begin
			tbl.rd_data <= mem[tbl.rd_addr];
		end
	end
endmodule : ffss_list_mem

// ---- verilog/ffss_top.sv ----
// Purpose: Chooses the correction entry applied to each acquired frame
// Assumes: FRAME_START is a one-cycle pulse synchronous to CLK
// Notes:   Set list edits take effect at the next set selection
`timescale 1ns/100ps
`include "ffss_regs.svh"

module ffss_top (
	// Clock and reset
	input wire logic CLK,
	input wire logic SRST,
	// Avalon-MM slave
	input wire logic [`FFSS_ADDR_W-1:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [31:0] AVS_WRITEDATA,
	input wire logic [3:0] AVS_BYTEENABLE,
	output logic [31:0] AVS_READDATA,
	output logic AVS_WAITREQUEST,
	// Acquisition side
	input wire logic FRAME_START,
	input wire logic FIRST_BUF_EMPTY,
	input wire logic COEF_UPLOAD_REQ,
	input wire logic [`FFSS_ENTRY_W-1:0] COEF_UPLOAD_ENTRY,
	// Correction path
	output logic [`FFSS_ENTRY_W-1:0] ENTRY_INDEX,
	output logic ENTRY_VALID,
	output logic UPLOAD_GRANT
);
	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	ffss_tbl_if tbl ();
	logic ack;
	logic acq_on;
	ffss_pkg::ffss_mode_e mode;
	ffss_pkg::ffss_entry_t manual_idx;
	ffss_pkg::ffss_entry_t pos;
	ffss_pkg::ffss_list_s cur_list;
	ffss_pkg::ffss_list_s pend_list;
	ffss_pkg::ffss_set_t cur_set;
	ffss_pkg::ffss_set_t pend_set;
	logic pend;
	logic auto_on;
	logic wr_acc;
	logic set_commit;
	logic recon_commit;
	logic pair_commit;
	logic frame_adv;
	logic last_pos;
	ffss_pkg::ffss_entry_t eff_len;
	ffss_pkg::ffss_entry_t pair_mod;
	ffss_pkg::ffss_set_t sel_set;
	ffss_pkg::ffss_entry_t next_entry;
	logic [31:0] next_rdata;

	ffss_list_mem #(.SETS(`FFSS_NUM_SETS)) u_mem (
		.CLK(CLK),
		.SRST(SRST),
		.tbl(tbl.mem)
	);

	// ----------------------------------------
	// Bus slave
	// ----------------------------------------
	// Every access waits one cycle, time for the list read to land
	assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~ack;
	assign wr_acc = AVS_WRITE & ack & AVS_BYTEENABLE[0];
	assign sel_set = AVS_WRITEDATA[`FFSS_SET_W-1:0];
	assign set_commit = wr_acc && AVS_ADDRESS == `FFSS_OFS_SET_SEL;
	assign recon_commit = wr_acc && AVS_ADDRESS == `FFSS_OFS_RECONNECT && AVS_WRITEDATA[0];
	assign pair_commit = wr_acc && AVS_ADDRESS == `FFSS_OFS_PAIR && !acq_on;

	always_ff @(posedge CLK) begin
		if (SRST) begin
			ack <= 1'b0;
		end else begin
			ack <= (AVS_READ | AVS_WRITE) & ~ack;
		end
	end

	// Read mux, unmapped offsets read zero
	always_comb begin
		next_rdata = 32'h0000_0000;
		unique case (AVS_ADDRESS)
			`FFSS_OFS_MODE: next_rdata[0] = auto_on;
			`FFSS_OFS_ACQ: next_rdata[0] = acq_on;
			`FFSS_OFS_MANUAL: next_rdata[`FFSS_ENTRY_W-1:0] = manual_idx;
			`FFSS_OFS_SET_SEL: next_rdata[`FFSS_SET_W-1:0] = pend ? pend_set : cur_set;
			`FFSS_OFS_STATUS: begin
				next_rdata[`FFSS_ENTRY_W-1:0] = ENTRY_INDEX;
				next_rdata[`FFSS_STAT_SET_LSB +: `FFSS_SET_W] = cur_set;
				next_rdata[`FFSS_STAT_PEND_BIT] = pend;
				next_rdata[`FFSS_STAT_POS_LSB +: `FFSS_ENTRY_W] = pos;
			end
			default: next_rdata = 32'h0000_0000;
		endcase
	end

	// Read data settle in the wait cycle and stand at the accept edge
	always_ff @(posedge CLK) begin
		if (SRST) begin
			AVS_READDATA <= 32'h0000_0000;
		end else if (AVS_READ && !ack) begin
			AVS_READDATA <= next_rdata;
		end
	end

	// ----------------------------------------
	// Software settings
	// ----------------------------------------
	assign auto_on = mode == ffss_pkg::FFSS_MODE_AUTO;

	// Mode writes during capture are dropped, sequencer never sees a live swap
	always_ff @(posedge CLK) begin
		if (SRST) begin
			mode <= ffss_pkg::ffss_mode_e'(`FFSS_RST_MODE);
		end else if (wr_acc && AVS_ADDRESS == `FFSS_OFS_MODE && !acq_on) begin
			mode <= ffss_pkg::ffss_mode_e'(AVS_WRITEDATA[0]);
		end
	end

	// Acquisition run flag and manual choice
	always_ff @(posedge CLK) begin
		if (SRST) begin
			acq_on <= 1'b0;
			manual_idx <= `FFSS_RST_MANUAL;
		end else begin
			if (wr_acc && AVS_ADDRESS == `FFSS_OFS_ACQ) begin
				acq_on <= AVS_WRITEDATA[0];
			end
			if (wr_acc && AVS_ADDRESS == `FFSS_OFS_MANUAL) begin
				manual_idx <= AVS_WRITEDATA[`FFSS_ENTRY_W-1:0];
			end
		end
	end

	// List table: write port from bus, read port looks up the set being selected
	assign tbl.wr_en = AVS_WRITE && ack && AVS_ADDRESS == `FFSS_OFS_LIST_WR && (&AVS_BYTEENABLE[2:0]);
	assign tbl.wr_addr = sel_set;
	assign tbl.wr_data = '{len: AVS_WRITEDATA[`FFSS_LIST_LEN_LSB +: `FFSS_ENTRY_W],
		base: AVS_WRITEDATA[`FFSS_LIST_BASE_LSB +: `FFSS_ENTRY_W]};
	assign tbl.rd_addr = sel_set;

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	// Empty list treated as one entry so the modulo never divides by zero
	assign eff_len = (cur_list.len == '0) ? ffss_pkg::ffss_entry_t'(1) : cur_list.len;
	assign last_pos = (pos + ffss_pkg::ffss_entry_t'(1)) >= eff_len;
	assign pair_mod = AVS_WRITEDATA[`FFSS_ENTRY_W-1:0] % eff_len;
	assign frame_adv = FRAME_START && acq_on && auto_on;

	// Position and set state; later commands override the frame step
	always_ff @(posedge CLK) begin
		if (SRST) begin
			pos <= '0;
			cur_list <= '0;
			pend_list <= '0;
			cur_set <= '0;
			pend_set <= '0;
			pend <= 1'b0;
		end else begin
			if (frame_adv) begin
				if (last_pos) begin
					pos <= '0;
					if (pend) begin
						cur_list <= pend_list;
						cur_set <= pend_set;
						pend <= 1'b0;
					end
				end else begin
					pos <= pos + ffss_pkg::ffss_entry_t'(1);
				end
			end
			if (set_commit) begin
				if (acq_on && auto_on) begin
					pend <= 1'b1;
					pend_list <= tbl.rd_data;
					pend_set <= sel_set;
				end else begin
					cur_list <= tbl.rd_data;
					cur_set <= sel_set;
					pend <= 1'b0;
					pos <= '0;
				end
			end
			if (recon_commit && auto_on && FIRST_BUF_EMPTY) begin
				pos <= '0;
			end
			if (pair_commit) begin
				pos <= pair_mod;
			end
		end
	end

	// Manual mode uses the chosen index whatever set it sits in
	assign next_entry = auto_on ? cur_list.base + pos : manual_idx;

	// Entry captured once per frame and frozen for all its lines
	always_ff @(posedge CLK) begin
		if (SRST) begin
			ENTRY_INDEX <= '0;
			ENTRY_VALID <= 1'b0;
		end else if (!acq_on) begin
			ENTRY_VALID <= 1'b0;
		end else if (FRAME_START) begin
			ENTRY_INDEX <= next_entry;
			ENTRY_VALID <= 1'b1;
		end
	end

	// Upload granted unless it hits the entry in use; active-set safety is software's
	always_ff @(posedge CLK) begin
		if (SRST) begin
			UPLOAD_GRANT <= 1'b0;
		end else begin
			UPLOAD_GRANT <= COEF_UPLOAD_REQ && (!acq_on || COEF_UPLOAD_ENTRY != ENTRY_INDEX);
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge CLK); endclocking
	default disable iff (SRST);

	a_auto_advance: assert property ((frame_adv && !last_pos && !set_commit && !recon_commit && !pair_commit)
		|=> pos == $past(pos) + ffss_pkg::ffss_entry_t'(1)) else $error("auto step missed");
	a_manual_entry: assert property ((!auto_on && acq_on && FRAME_START)
		|=> ENTRY_INDEX == $past(manual_idx)) else $error("manual index not applied");
	a_manual_noset: assert property ((set_commit && !auto_on)
		|=> !pend && cur_set == $past(sel_set)) else $error("set deferred in manual mode");
	a_upload_block: assert property ((COEF_UPLOAD_REQ && acq_on && COEF_UPLOAD_ENTRY == ENTRY_INDEX)
		|=> !UPLOAD_GRANT) else $error("upload granted to entry in use");
	a_defer_switch: assert property ((set_commit && auto_on && acq_on && !FRAME_START)
		|=> pend && cur_set == $past(cur_set)) else $error("set switched mid pass");
	a_pass_switch: assert property ((frame_adv && last_pos && pend && !set_commit)
		|=> cur_set == $past(pend_set) && pos == '0) else $error("pending set not taken");
	a_set_restart: assert property ((set_commit && !(auto_on && acq_on) && !recon_commit && !pair_commit)
		|=> pos == '0) else $error("set select did not restart");
	a_reconnect: assert property ((recon_commit && auto_on && FIRST_BUF_EMPTY)
		|=> pos == '0) else $error("reconnect did not restart");
	a_pair_start: assert property (pair_commit
		|=> pos == $past(pair_mod) && pos < $past(eff_len)) else $error("pair start wrong");
	a_set_track: assert property (set_commit
		|=> cur_set == $past(sel_set) || pend_set == $past(sel_set)) else $error("set lost");
	a_frame_hold: assert property (!(FRAME_START && acq_on)
		|=> $stable(ENTRY_INDEX)) else $error("entry changed inside frame");

	c_list_wrap: cover property (frame_adv && last_pos);
	c_deferred: cover property (frame_adv && last_pos && pend);
	c_manual: cover property (!auto_on && acq_on && FRAME_START);
	c_grant: cover property (UPLOAD_GRANT && acq_on);
endmodule : ffss_top

// ---- test/tb.sv ----
// Purpose: Self-checking bench for the correction entry selector
// Assumes: One clock, Avalon-MM slave with one wait cycle per access
// Notes:   Driver queues expectations, the monitor pops them as results appear
`timescale 1ns/100ps
`include "ffss_regs.svh"

// Queue word is mask in the upper half, expected value in the lower half
`define CHECK(got, exp) begin \
	n_checks++; \
	if ((got) !== (exp)) begin \
		fails++; \
		$display("Error at %0t: got %h expected %h", $time, got, exp); \
	end \
end

module tb;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic CLK, SRST, AVS_READ, AVS_WRITE, AVS_WAITREQUEST, FRAME_START, FIRST_BUF_EMPTY;
	logic COEF_UPLOAD_REQ, ENTRY_VALID, UPLOAD_GRANT;
	logic [`FFSS_ADDR_W-1:0] AVS_ADDRESS;
	logic [3:0] AVS_BYTEENABLE;
	logic [31:0] AVS_WRITEDATA, AVS_READDATA;
	logic [`FFSS_ENTRY_W-1:0] COEF_UPLOAD_ENTRY, ENTRY_INDEX, m, p;
	logic [63:0] q[$];
	int fails, n_checks, seed;

	ffss_top ffss_top_i (.CLK(CLK), .SRST(SRST), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
		.AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
		.AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .FRAME_START(FRAME_START),
		.FIRST_BUF_EMPTY(FIRST_BUF_EMPTY), .COEF_UPLOAD_REQ(COEF_UPLOAD_REQ),
		.COEF_UPLOAD_ENTRY(COEF_UPLOAD_ENTRY), .ENTRY_INDEX(ENTRY_INDEX), .ENTRY_VALID(ENTRY_VALID),
		.UPLOAD_GRANT(UPLOAD_GRANT));

	// Free running 125 MHz clock
	initial begin
		CLK = 1'b0;
		forever #4 CLK = ~CLK;
	end

	// ----------------------------------------
	// Monitor
	// ----------------------------------------
	task automatic chk(input logic [31:0] got);
		logic [63:0] e;
		e = (q.size() > 0) ? q.pop_front() : '1;
		`CHECK(got & e[63:32], e[31:0])
	endtask : chk

	// Samples pre-edge requests, looks at results once the edge has landed
	always @(posedge CLK) begin
		logic r, f, u;
		logic [31:0] rdat;
		r = AVS_READ && !AVS_WAITREQUEST;
		rdat = AVS_READDATA;
		f = FRAME_START;
		u = COEF_UPLOAD_REQ;
		#1;
		if (r) chk(rdat);
		if (f) chk({23'h00_0000, ENTRY_VALID, ENTRY_INDEX});
		if (u) chk({31'h0, UPLOAD_GRANT});
	end

	// ----------------------------------------
	// Driver tasks
	// ----------------------------------------
	// Holds the request until waitrequest is seen low; only the watchdog ends a hang
	task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
		AVS_WRITE <= w;
		AVS_READ <= !w;
		AVS_ADDRESS <= a;
		AVS_WRITEDATA <= d;
		@(posedge CLK);
		while (AVS_WAITREQUEST) begin
			@(posedge CLK);
		end
		AVS_WRITE <= 1'b0;
		AVS_READ <= 1'b0;
		@(posedge CLK);
	endtask : bus

	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask : wr

	task automatic rd(input logic [5:0] a, input logic [31:0] msk, input logic [31:0] e);
		q.push_back({msk, e});
		bus(1'b0, a, 32'h0000_0000);
	endtask : rd

	// Expects the entry and the valid flag one edge after the pulse
	task automatic frame(input logic [7:0] e, input logic v = 1'b1);
		q.push_back({32'h0000_01FF, 23'h00_0000, v, e});
		FRAME_START <= 1'b1;
		@(posedge CLK);
		FRAME_START <= 1'b0;
		@(posedge CLK);
	endtask : frame

	task automatic upl(input logic [7:0] ent, input logic g);
		q.push_back({32'h0000_0001, 31'h0, g});
		COEF_UPLOAD_REQ <= 1'b1;
		COEF_UPLOAD_ENTRY <= ent;
		@(posedge CLK);
		COEF_UPLOAD_REQ <= 1'b0;
		COEF_UPLOAD_ENTRY <= 8'($random(seed));
		@(posedge CLK);
	endtask : upl

	// Each set gets its own base and a length of three to six
	function automatic logic [7:0] lbase(input int s);
		return 8'(s * 16);
	endfunction : lbase

	function automatic logic [7:0] llen(input int s);
		return 8'(s % 4 + 3);
	endfunction : llen

	task automatic note(input string s);
		$display("test %s done at %0t", s, $time);
	endtask : note

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : tally_and_finish

	// Whole run needs well under a thousand cycles; the 20000-cycle limit is ample
	initial begin
		#(8 * 20000);
		fails++;
		tally_and_finish();
	end

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial begin
		seed = 33;
		{AVS_READ, AVS_WRITE, FRAME_START, COEF_UPLOAD_REQ} = 4'h0;
		{AVS_ADDRESS, AVS_WRITEDATA, COEF_UPLOAD_ENTRY} = '0;
		AVS_BYTEENABLE = 4'hF;
		FIRST_BUF_EMPTY = 1'b1;
		SRST = 1'b1;
		repeat (2) @(posedge CLK);
		SRST <= 1'b0;
		@(posedge CLK);
		rd(`FFSS_OFS_STATUS, '1, 32'h0000_0000);
		rd(`FFSS_OFS_MODE, '1, 32'h0000_0000);
		rd(6'h20, '1, 32'h0000_0000);
		// Lane 0 off: the write must be dropped
		AVS_BYTEENABLE <= 4'hE;
		wr(`FFSS_OFS_MANUAL, 32'h0000_00AB);
		AVS_BYTEENABLE <= 4'hF;
		rd(`FFSS_OFS_MANUAL, '1, 32'h0000_0000);
		note("reset");
		for (int s = 0; s < 16; s++) wr(`FFSS_OFS_LIST_WR, {8'h00, llen(s), lbase(s), 4'h0, 4'(s)});
		m = 8'($random(seed));
		wr(`FFSS_OFS_MANUAL, {24'h0, m});
		wr(`FFSS_OFS_SET_SEL, 32'h0000_0005);
		wr(`FFSS_OFS_ACQ, 32'h0000_0001);
		frame(m);
		wr(`FFSS_OFS_MANUAL, {24'h0, m ^ 8'h5A});
		rd(`FFSS_OFS_STATUS, 32'h0000_00FF, {24'h0, m});
		frame(m ^ 8'h5A);
		upl(m ^ 8'h5A, 1'b0);
		upl(m ^ 8'h5B, 1'b1);
		wr(`FFSS_OFS_MODE, 32'h0000_0001);
		rd(`FFSS_OFS_MODE, 32'h0000_0001, 32'h0000_0000);
		wr(`FFSS_OFS_ACQ, 32'h0000_0000);
		wr(`FFSS_OFS_MODE, 32'h0000_0001);
		rd(`FFSS_OFS_MODE, 32'h0000_0001, 32'h0000_0001);
		note("manual");
		// Every set, one full pass plus the wrap back to its first entry
		for (int s = 0; s < 16; s++) begin
			wr(`FFSS_OFS_SET_SEL, 32'(s));
			wr(`FFSS_OFS_ACQ, 32'h0000_0001);
			for (int k = 0; k <= llen(s); k++) frame(lbase(s) + 8'(k % llen(s)));
			wr(`FFSS_OFS_ACQ, 32'h0000_0000);
		end
		note("auto");
		wr(`FFSS_OFS_SET_SEL, 32'h0000_0001);
		wr(`FFSS_OFS_ACQ, 32'h0000_0001);
		frame(8'h10);
		wr(`FFSS_OFS_SET_SEL, 32'h0000_0002);
		rd(`FFSS_OFS_SET_SEL, '1, 32'h0000_0002);
		rd(`FFSS_OFS_STATUS, '1, 32'h0001_1110);
		for (int k = 1; k < 4; k++) frame(8'(16 + k));
		frame(8'h20);
		frame(8'h21);
		FIRST_BUF_EMPTY <= 1'b0;
		wr(`FFSS_OFS_RECONNECT, 32'h0000_0001);
		frame(8'h22);
		FIRST_BUF_EMPTY <= 1'b1;
		wr(`FFSS_OFS_RECONNECT, 32'h0000_0001);
		frame(8'h20);
		note("deferred and reconnect");
		wr(`FFSS_OFS_ACQ, 32'h0000_0000);
		wr(`FFSS_OFS_SET_SEL, 32'h0000_0003);
		p = 8'($random(seed));
		wr(`FFSS_OFS_PAIR, {24'h0, p});
		wr(`FFSS_OFS_ACQ, 32'h0000_0001);
		frame(8'h30 + p % 8'd6);
		wr(`FFSS_OFS_ACQ, 32'h0000_0000);
		frame(8'h30 + p % 8'd6, 1'b0);
		note("pair");
		tally_and_finish();
	end
endmodule : tb
